// ### verilog/rcs_reference_clock_selector.sv
// Purpose: pick one of two reference inputs for the PLL, with hold-off holdover
// Assumes: reference inputs sampled as synchronous levels, clk is the VCXO clock
// Notes: mode 1,1,x is treated as plain manual control
//
// Behaviour
// - Decode holdover enable and mode bits.
// - Manual modes follow pin or register select.
// - Manual modes keep lost reference, no holdover.
// - Holdover mode: user change enters holdover, loads counter.
// - Holdover mode: switch and leave at expiry.
// - Holdover lasts count times prescale VCXO periods.
// - Holdover ends even if new input lost.
// - Holdover mode flags: hold, selection, status.
// - Plain manual: switch at once, real status.
// - Automatic: failing selected input swaps input.
// - Automatic: primary loss switches without holdover.
// - Automatic flags: machine choice, real status, hold=1.
// - Automatic: no valid input, no switch, unlocked.
// - Automatic: relock after input revalidates.
// - Automatic: user change switches directly, even invalid.
// - Loss after three missing edges versus monitor.
// - Revalidate after configured consecutive input periods.
`timescale 1ns/100ps
module rcs_reference_clock_selector
	import rcs_pkg::*;
#(
	parameter int CNT_W = RCS_CNT_W,
	parameter int VAL_W = RCS_VAL_W,
	parameter int MON_W = RCS_MON_W
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic holdoverEnableN,        // Low selects holdover manual mode
	input wire logic modeSelectHiN,          // Mode select high bit
	input wire logic modeSelectLoN,          // Mode select low bit
	input wire logic externalRefSelectPin,   // Select pin
	input wire logic internalRefSelect,      // Select register bit
	input wire logic useExternalSelect,      // High: pin chooses, low: register
	input wire logic [1:0] refClk,           // Sampled reference inputs
	input wire logic [MON_W-1:0] monitorDivide,     // VCXO divide for monitor
	input wire logic [CNT_W-1:0] holdoffCount,      // Hold-off down-count
	input wire logic [CNT_W-1:0] holdoffPrescaleCount, // VCXO periods per step
	input wire logic [VAL_W-1:0] revalidationCount, // Good periods to revalidate
	output logic [1:0] inputLossFlag,        // Loss per input
	output logic holdoverFlagN,              // Low during holdover
	output logic selectedInputFlag,          // Chosen input
	output logic referenceStatusFlag,        // Loss status of chosen input
	output logic pllRefSelect,               // Input feeding the PLL
	output logic pllUnlocked                 // No usable reference
);
	// ==========================================
	// Mode decode
	rcs_mode_e mode;
	logic userSel;

	// Mode from the three control bits
	always_comb begin
		if (!holdoverEnableN) begin
			mode = RCS_MODE_HOLD_MANUAL;
		end else if (!modeSelectHiN && modeSelectLoN) begin
			mode = RCS_MODE_AUTO;
		end else begin
			mode = RCS_MODE_MANUAL;
		end
		userSel = useExternalSelect ? externalRefSelectPin : internalRefSelect;
	end

	// ==========================================
	// Monitor divider
	logic [MON_W-1:0] monCnt, next_monCnt;
	logic monTick, next_monTick;

	// Divided VCXO tick, one cycle wide
	always_comb begin
		next_monTick = 1'b0;
		next_monCnt = monCnt + 1'b1;
		if (monCnt + 1'b1 >= monitorDivide) begin
			next_monCnt = '0;
			next_monTick = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			monCnt <= '0;
			monTick <= 1'b0;
		end else begin
			monCnt <= next_monCnt;
			monTick <= next_monTick;
		end
	end

	// ==========================================
	// Loss detectors, one per input
	wire [1:0] lost; // One bit per detector instance
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_mon
			logic prevClk, edgeSeen, lostQ, next_lostQ;
			logic [1:0] missCnt, next_missCnt;
			logic [VAL_W-1:0] goodCnt, next_goodCnt;
			assign edgeSeen = refClk[gi] && !prevClk;
			// Count ticks without an edge and edges while lost
			always_comb begin
				next_missCnt = missCnt;
				next_goodCnt = goodCnt;
				next_lostQ = lostQ;
				if (edgeSeen) begin
					next_missCnt = '0;
				end else if (monTick && missCnt != 2'(RCS_LOSS_EDGES)) begin
					next_missCnt = missCnt + 1'b1;
				end
				if (!edgeSeen && monTick && missCnt == 2'(RCS_LOSS_EDGES - 1)) begin
					next_lostQ = 1'b1;
					next_goodCnt = '0;
				end else if (lostQ && edgeSeen) begin
					next_goodCnt = goodCnt + 1'b1;
					if (goodCnt + 1'b1 >= revalidationCount) begin
						next_lostQ = 1'b0;
						next_goodCnt = '0;
					end
				end else if (lostQ && missCnt != '0 && monTick) begin
					// Gap breaks the run
					next_goodCnt = '0;
				end
			end

			always_ff @(posedge clk) begin
				if (!rst_n) begin
					prevClk <= 1'b0;
					missCnt <= '0;
					goodCnt <= '0;
					lostQ <= 1'b0;
				end else begin
					prevClk <= refClk[gi];
					missCnt <= next_missCnt;
					goodCnt <= next_goodCnt;
					lostQ <= next_lostQ;
				end
			end
			assign lost[gi] = lostQ;
		end
	endgenerate

	// ==========================================
	// Selection and hold-off
	logic activeSel, next_activeSel;
	logic lastUser, next_lastUser;
	logic holdover, next_holdover;
	logic [CNT_W-1:0] holdCnt, next_holdCnt;
	logic [CNT_W-1:0] preCnt, next_preCnt;
	logic expire;
	logic [1:0] lostSeen, next_lostSeen; // Loss state one cycle back
	logic swapEvent; // Automatic swap condition

	// Expiry on the last prescale step of the last hold-off step
	assign expire = (holdCnt <= 1) && (preCnt <= 1);

	// Swap only on a fresh loss of the active input or a fresh return of the spare;
	// a user pick of a dead input then stays put and the PLL may stall
	assign swapEvent = lost[activeSel] && !lost[!activeSel] && (!lostSeen[activeSel] || lostSeen[!activeSel]);

	always_comb begin
		next_activeSel = activeSel;
		next_lastUser = userSel;
		next_holdover = holdover;
		next_holdCnt = holdCnt;
		next_preCnt = preCnt;
		next_lostSeen = lost;
		case (mode)
			RCS_MODE_HOLD_MANUAL: begin
				if (holdover) begin
					// count prescale periods per hold-off step
					if (preCnt > 1) begin
						next_preCnt = preCnt - 1'b1;
					end else begin
						next_preCnt = holdoffPrescaleCount;
						next_holdCnt = holdCnt - 1'b1;
					end
					// switch at expiry, regardless of loss
					if (expire) begin
						next_activeSel = userSel;
						next_holdover = 1'b0;
					end
				end else if (userSel != activeSel) begin
					next_holdover = 1'b1;
					next_holdCnt = holdoffCount;
					next_preCnt = holdoffPrescaleCount;
				end
				// loss alone never moves the choice
			end
			RCS_MODE_MANUAL: begin
				next_activeSel = userSel;
				next_holdover = 1'b0;
			end
			RCS_MODE_AUTO: begin
				next_holdover = 1'b0;
				if (userSel != lastUser) begin
					next_activeSel = userSel;
				end else if (swapEvent) begin
					next_activeSel = !activeSel;
				end
			end
			default: begin
				next_holdover = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			activeSel <= RCS_IN_PRIMARY;
			lastUser <= RCS_IN_PRIMARY;
			holdover <= 1'b0;
			holdCnt <= '0;
			preCnt <= '0;
			lostSeen <= '0;
		end else begin
			activeSel <= next_activeSel;
			lastUser <= next_lastUser;
			holdover <= next_holdover;
			holdCnt <= next_holdCnt;
			preCnt <= next_preCnt;
			lostSeen <= next_lostSeen;
		end
	end

	// ==========================================
	// Status outputs
	logic next_selFlag, next_refFlag;

	always_comb begin
		// holdover mode shows the user's choice
		next_selFlag = (mode == RCS_MODE_HOLD_MANUAL) ? userSel : activeSel;
		next_refFlag = lost[activeSel];
		if (mode == RCS_MODE_HOLD_MANUAL) begin
			// status only while a switch is pending
			next_refFlag = holdover ? lost[userSel] : 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			inputLossFlag <= '0;
			holdoverFlagN <= 1'b1;
			selectedInputFlag <= RCS_IN_PRIMARY;
			referenceStatusFlag <= 1'b0;
			pllRefSelect <= RCS_IN_PRIMARY;
			pllUnlocked <= 1'b0;
		end else begin
			inputLossFlag <= lost;
			holdoverFlagN <= !holdover;
			selectedInputFlag <= next_selFlag;
			referenceStatusFlag <= next_refFlag;
			pllRefSelect <= activeSel;
			pllUnlocked <= lost[activeSel];
		end
	end

	// ==========================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_manual_no_hold: assert property (mode == RCS_MODE_MANUAL |=> !holdover)
		else $error("holdover in plain manual mode");
	chk_hold_entry: assert property (mode == RCS_MODE_HOLD_MANUAL && !holdover && userSel != activeSel
		|=> holdover && holdCnt == $past(holdoffCount))
		else $error("holdover not entered on change");
	chk_hold_switch: assert property (mode == RCS_MODE_HOLD_MANUAL && holdover
		&& !(holdCnt <= 1 && preCnt <= 1) |=> $stable(activeSel))
		else $error("switch before expiry");
	chk_hold_exit: assert property (mode == RCS_MODE_HOLD_MANUAL && holdover && expire |=> !holdover)
		else $error("holdover not ended at expiry");
	chk_flag_hold: assert property (holdover |=> !holdoverFlagN)
		else $error("holdover flag wrong");
	chk_manual_follow: assert property (mode == RCS_MODE_MANUAL |=> activeSel == $past(userSel))
		else $error("plain manual did not follow");
	chk_auto_swap: assert property (mode == RCS_MODE_AUTO && userSel == lastUser && lost[activeSel]
		&& !lost[!activeSel] && !lostSeen[activeSel] |=> activeSel != $past(activeSel))
		else $error("auto did not swap");
	chk_auto_stay: assert property (mode == RCS_MODE_AUTO && userSel == lastUser && lost == 2'h3
		|=> $stable(activeSel) && !holdover)
		else $error("auto moved with no valid input");
	chk_auto_flag: assert property (mode == RCS_MODE_AUTO ##1 mode == RCS_MODE_AUTO |=> holdoverFlagN)
		else $error("hold flag low in auto");
	chk_auto_user: assert property (mode == RCS_MODE_AUTO && userSel != lastUser |=> activeSel == $past(userSel))
		else $error("auto user change ignored");
	chk_ref_idle: assert property (mode == RCS_MODE_HOLD_MANUAL && !holdover |=> !referenceStatusFlag)
		else $error("status flag set with no switch pending");
	chk_sel_hold: assert property (mode == RCS_MODE_HOLD_MANUAL |=> selectedInputFlag == $past(userSel))
		else $error("selection flag not the user choice");
	chk_sel_auto: assert property (mode == RCS_MODE_AUTO |=> selectedInputFlag == $past(activeSel))
		else $error("selection flag not the machine choice");

	cov_holdover: cover property (holdover ##1 !holdover);
	cov_auto_swap: cover property (mode == RCS_MODE_AUTO && $changed(activeSel));
	cov_loss: cover property ($rose(lost[0]));
endmodule

// ### verilog/rcs_pkg.sv
// Purpose: shared constants and types of the reference clock selector
// Assumes: one clock derived from the VCXO
// Notes: widths here are defaults for the selector parameters
package rcs_pkg;
	// ==========================================
	// Selection modes
	typedef enum {RCS_MODE_HOLD_MANUAL, RCS_MODE_MANUAL, RCS_MODE_AUTO} rcs_mode_e;

	// ==========================================
	// Counter widths and figures
	localparam int RCS_CNT_W = 16;       // Hold-off and prescale count width
	localparam int RCS_VAL_W = 8;        // Revalidation count width
	localparam int RCS_MON_W = 5;        // Monitor divider width
	localparam int RCS_MON_DIV = 5;      // Default monitor divide ratio
	localparam int RCS_LOSS_EDGES = 3;   // Missing edges that declare loss
	localparam logic RCS_IN_PRIMARY = 1'h0; // Selection after reset
endpackage

// ### tb/rcs_ref_source.sv
// Purpose: model of one reference clock source feeding the selector
// Assumes: the source toggles once per clk while running
// Notes: a stopped source parks low, as a dead input does
`timescale 1ns/100ps
module rcs_ref_source (
	input wire logic clk,
	input wire logic run,
	output logic refOut = 1'h0
);
	// Toggle while running, hold low once stopped
	always @(posedge clk) begin
		refOut <= run ? !refOut : 1'h0;
	end
endmodule

// ### tb/testbench.sv
// Purpose: self-checking bench for the reference clock selector
// Assumes: two behavioural sources, monitor tick every 4 clk
// Notes: expectations come from a small integer model of the selection
`timescale 1ns/100ps
`define CHK(g, e, m) begin checks++; if ((g) !== (e)) begin miscompares++; $display("[FAIL] %0t %s", $time, m); end end
module testbench;
	import rcs_pkg::*;
	// ==========================================
	// Stimulus and observed signals
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic hoEnN = 1'h0, hiN = 1'h1, loN = 1'h1, pin = 1'h0, regSel = 1'h0, useExt = 1'h0;
	logic [1:0] run = 2'h3;
	wire [1:0] refClk;
	logic [RCS_CNT_W-1:0] hoCnt = 16'h0002, hoPre = 16'h0002;
	logic [1:0] lossFlag;
	logic holdN, selFlag, refStat, pllSel, pllUnl;
	int miscompares = 0, checks = 0, modelSel = 0, lowCycles, nxt;
	int expHold[$]; // Expected holdover lengths, oldest first
	// Clock of 5 ns period
	always #2.5 clk = !clk;
	// ==========================================
	// Sources and design
	rcs_ref_source src0 (.clk(clk), .run(run[0]), .refOut(refClk[0]));
	rcs_ref_source src1 (.clk(clk), .run(run[1]), .refOut(refClk[1]));
	rcs_reference_clock_selector uut (.clk(clk), .rst_n(rst_n), .holdoverEnableN(hoEnN), .modeSelectHiN(hiN),
		.modeSelectLoN(loN), .externalRefSelectPin(pin), .internalRefSelect(regSel), .useExternalSelect(useExt),
		.refClk(refClk), .monitorDivide(5'h04), .holdoffCount(hoCnt), .holdoffPrescaleCount(hoPre),
		.revalidationCount(8'h04), .inputLossFlag(lossFlag), .holdoverFlagN(holdN), .selectedInputFlag(selFlag),
		.referenceStatusFlag(refStat), .pllRefSelect(pllSel), .pllUnlocked(pllUnl));
	// ==========================================
	// Helpers
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Set both select sources to one input, let it land
	task automatic pick(input int s);
		@(posedge clk);
		pin <= s[0];
		regSel <= s[0];
		settle(3);
	endtask
	// Flip the user choice in holdover mode and time the holdover
	task automatic holdTrial(input int cnt, input int pre, input bit viaPin, input bit lose);
		nxt = 1 - modelSel;
		expHold.push_back(cnt * pre);
		if (lose) begin
			@(posedge clk);
			run[nxt] <= 1'h0;
			settle(30);
		end
		@(posedge clk);
		hoCnt <= cnt[RCS_CNT_W-1:0];
		hoPre <= pre[RCS_CNT_W-1:0];
		useExt <= viaPin;
		pin <= viaPin ? nxt[0] : modelSel[0];
		regSel <= viaPin ? modelSel[0] : nxt[0];
		lowCycles = 0;
		for (int i = 1; i <= cnt * pre + 8; i++) begin
			settle(1);
			lowCycles += int'(holdN === 1'h0);
			if (i == 3) begin
				`CHK(selFlag, nxt[0], "user choice flag")
				`CHK(refStat, lose, "pending input status")
				`CHK(pllSel, modelSel[0], "switched before expiry")
			end
		end
		`CHK(lowCycles, expHold.pop_front(), "holdover length")
		`CHK(pllSel, nxt[0], "switch at expiry")
		`CHK(holdN, 1'h1, "holdover left")
		modelSel = nxt;
		@(posedge clk);
		pin <= nxt[0];
		regSel <= nxt[0];
		run <= 2'h3;
		settle(6);
		`CHK(lossFlag != 2'h0, lose, "revalidated too early")
		settle(34);
		`CHK(lossFlag, 2'h0, "input revalidated")
	endtask
	// Print counts and verdict
	task automatic end_of_test;
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// ==========================================
	// Watchdog
	initial begin
		#(5 * 8000);
		miscompares++;
		end_of_test;
	end
	// ==========================================
	// Main sequence
	initial begin
		void'($urandom(37));
		repeat (3) @(posedge clk);
		rst_n <= 1'h1;
		#1;
		`CHK({lossFlag, holdN, selFlag, refStat, pllSel}, 6'h08, "reset values")
		settle(20);
		for (int t = 0; t < 3; t++) begin
			holdTrial($urandom_range(4, 2), $urandom_range(4, 2), t == 1, t == 2);
		end
		// Plain manual: lose the active input
		@(posedge clk);
		hoEnN <= 1'h1;
		hiN <= 1'h0;
		loN <= 1'h0;
		run[modelSel] <= 1'h0;
		settle(30);
		`CHK(lossFlag[modelSel], 1'h1, "loss declared")
		`CHK(pllSel, modelSel[0], "lost input kept")
		`CHK(holdN, 1'h1, "no holdover on loss")
		nxt = 1 - modelSel;
		pick(nxt);
		`CHK({holdN, pllSel, refStat}, {1'h1, nxt[0], 1'h0}, "immediate switch")
		pick(modelSel);
		`CHK({holdN, pllSel, refStat}, {1'h1, modelSel[0], 1'h1}, "switch to lost input")
		@(posedge clk);
		run <= 2'h3;
		settle(40);
		// Automatic mode from input 0
		@(posedge clk);
		loN <= 1'h1;
		pick(0);
		settle(10);
		@(posedge clk);
		run[0] <= 1'h0;
		settle(30);
		`CHK({pllSel, selFlag, refStat, holdN}, 4'hd, "failover to input 1")
		@(posedge clk);
		run[1] <= 1'h0;
		settle(30);
		`CHK({pllSel, pllUnl, holdN}, 3'h7, "no valid input")
		@(posedge clk);
		run[1] <= 1'h1;
		settle(40);
		`CHK({pllSel, pllUnl}, 2'h2, "relock after revalidation")
		pick(1);
		pick(0);
		`CHK({pllSel, holdN}, 2'h1, "user change to lost input")
		end_of_test;
	end
endmodule
